//--- hw/emc_ext_mem.sv
// What this block does
// RQ1: bit 4 of configuration picks shared pins (0) or separate pins (1).
// RQ2: shared style carries low address then data byte on the same eight pins.
// RQ3: shared style drives the address latch strobe from this logic.
// RQ4: first phase holds latch strobe high with low address on shared pins.
// RQ5: external latch follows while strobe high, freezes on its falling edge.
// RQ6: after strobe falls, shared pins carry data when read/write strobe asserts.
// RQ7: separate style puts address and data on distinct pins, none shared.
// RQ8: two-bit mode field selects one of four memory map modes.
// RQ9: two-bit field sets latch strobe high and low widths, shared style only.
// RQ10: mode 00 sends everything on-chip, addresses wrap every 1k.
// RQ11: mode 01 splits at RAM size; short form leaves upper address undriven.
// RQ12: mode 10 short form drives page register high byte, all sixteen bits.
// RQ13: mode 11 sends all off-chip; short form ignores page, upper undriven.
// RQ14: separate style keeps the latch strobe low, no spurious latch events.
//
// Purpose: external memory interface: config, memory map, bus phases
// Assumes: core requests synchronous to ref_clk; strobe width one cycle
// Notes:   requests queue in a 16-word FIFO ahead of the sequencer
`timescale 1ns/1ps

module emc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
  } emc_fifo_type;

  emc_fifo_type     s_reg;
  emc_fifo_type     s_next;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s_reg.count != CW'(DEPTH));
  assign out_valid = (s_reg.count != '0);
  assign out_data  = store[s_reg.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wptr = (s_reg.wptr == AW'(DEPTH - 1)) ? '0 : s_reg.wptr + 1'b1;
    end
    if (pop) begin
      s_next.rptr = (s_reg.rptr == AW'(DEPTH - 1)) ? '0 : s_reg.rptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
    if (push) begin
      store[s_reg.wptr] <= in_data;
    end
  end
endmodule : emc_fifo

module emc_ext_mem (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // configuration and page registers
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  input  wire logic        page_wr,
  input  wire logic [7:0]  page_wdata,
  output logic      [7:0]  page_rdata,
  // external move requests from the core
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_short,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  // completion
  output logic             resp_valid,
  output logic      [7:0]  resp_data,
  output logic             busy,
  // shared address/data or data pins
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  // separate low address pins
  output logic      [7:0]  addr_lo_out,
  output logic             addr_lo_oe,
  // upper address pins
  output logic      [7:0]  addr_hi_out,
  output logic             addr_hi_oe,
  // control strobes
  output logic             ale_out,
  output logic             rd_n_out,
  output logic             wr_n_out
);
  typedef struct packed {
    emc_pkg::emc_state_type st;
    logic [1:0]             cnt;
    logic [7:0]             cfg;
    logic [7:0]             page;
    logic [1:0]             ale_w;
    logic                   write;
    logic [7:0]             wdata;
    logic [7:0]             ad_out;
    logic                   ad_oe;
    logic [7:0]             lo_out;
    logic                   lo_oe;
    logic [7:0]             hi_out;
    logic                   hi_oe;
    logic                   ale;
    logic                   rd_n;
    logic                   wr_n;
    logic                   resp_valid;
    logic [7:0]             resp_data;
  } emc_core_type;

  emc_core_type              s_reg;
  emc_core_type              s_next;
  logic [7:0]                ram [emc_pkg::RAM_WORDS];
  logic                      q_valid;
  logic                      q_pop;
  logic [emc_pkg::REQ_W-1:0] q_data;
  logic                      q_write;
  logic                      q_short;
  logic [15:0]               q_addr;
  logic [7:0]                q_wdata;
  emc_pkg::emc_map_type      map;
  logic [15:0]               eff;
  logic                      go_ext;
  logic                      drive_hi;
  logic                      ram_we;
  logic [emc_pkg::RAM_AW-1:0] ram_idx;

  emc_fifo #(
    .WIDTH (emc_pkg::REQ_W),
    .DEPTH (emc_pkg::FIFO_DEPTH)
  ) u_req_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_short, req_addr, req_wdata}),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  assign {q_write, q_short, q_addr, q_wdata} = q_data;

  // ----------------------------------------------------------------
  // memory map decode
  // ----------------------------------------------------------------
  always_comb begin
    map = emc_pkg::emc_map_type'(s_reg.cfg[emc_pkg::CFG_MODE_LSB +: 2]); // RQ8
    eff = q_short ? {s_reg.page, q_addr[7:0]} : q_addr;
    drive_hi = !q_short;
    go_ext   = 1'b0;
    unique case (map)
      emc_pkg::EMC_MAP_INTERNAL: begin
        go_ext = 1'b0; // RQ10
      end
      emc_pkg::EMC_MAP_SPLIT: begin
        go_ext = (eff >= emc_pkg::INT_RAM_LIMIT); // RQ11
      end
      emc_pkg::EMC_MAP_BANKED: begin
        go_ext   = (eff >= emc_pkg::INT_RAM_LIMIT);
        drive_hi = 1'b1; // RQ12
      end
      emc_pkg::EMC_MAP_EXTERNAL: begin
        go_ext = 1'b1; // RQ13
        if (q_short) begin
          eff = {8'h00, q_addr[7:0]}; // RQ13
        end
      end
    endcase
    ram_idx = eff[emc_pkg::RAM_AW-1:0]; // RQ10
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next            = s_reg;
    s_next.resp_valid = 1'b0;
    q_pop             = 1'b0;
    ram_we            = 1'b0;
    if (cfg_wr) begin
      s_next.cfg = cfg_wdata & emc_pkg::CFG_USED_MASK; // RQ1
    end
    if (page_wr) begin
      s_next.page = page_wdata;
    end
    unique case (s_reg.st)
      emc_pkg::EMC_IDLE: begin
        if (q_valid) begin
          q_pop        = 1'b1;
          s_next.write = q_write;
          s_next.wdata = q_wdata;
          if (!go_ext) begin
            ram_we            = q_write;
            s_next.resp_valid = 1'b1;
            s_next.resp_data  = q_write ? 8'h00 : ram[ram_idx];
          end else begin
            s_next.ale_w  = emc_pkg::emc_ale_count(s_reg.cfg[emc_pkg::CFG_ALE_LSB +: 2]);
            s_next.hi_out = eff[15:8];
            s_next.hi_oe  = drive_hi; // RQ11
            if (!s_reg.cfg[emc_pkg::CFG_SHARE_BIT]) begin
              // first phase: low address on shared pins, latch open
              s_next.ad_out = eff[7:0]; // RQ2
              s_next.ad_oe  = 1'b1;
              s_next.ale    = 1'b1; // RQ3 RQ4
              s_next.cnt    = emc_pkg::emc_ale_count(s_reg.cfg[emc_pkg::CFG_ALE_LSB +: 2]); // RQ9
              s_next.st     = emc_pkg::EMC_ALE_HI;
            end else begin
              // address and data each on pins of their own
              s_next.lo_out = eff[7:0]; // RQ7
              s_next.lo_oe  = 1'b1;
              s_next.ad_out = q_wdata;
              s_next.ad_oe  = q_write;
              s_next.ale    = 1'b0; // RQ14
              s_next.rd_n   = q_write;
              s_next.wr_n   = !q_write;
              s_next.st     = emc_pkg::EMC_STROBE;
            end
          end
        end
      end
      emc_pkg::EMC_ALE_HI: begin
        if (s_reg.cnt == 2'h0) begin
          s_next.ale = 1'b0; // RQ5
          s_next.cnt = s_reg.ale_w; // RQ9
          s_next.st  = emc_pkg::EMC_ALE_LO;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      emc_pkg::EMC_ALE_LO: begin
        if (s_reg.cnt == 2'h0) begin
          // second phase: data owns the shared pins as the strobe asserts
          s_next.ad_out = s_reg.wdata; // RQ6
          s_next.ad_oe  = s_reg.write; // RQ6
          s_next.rd_n   = s_reg.write;
          s_next.wr_n   = !s_reg.write;
          s_next.st     = emc_pkg::EMC_STROBE;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      emc_pkg::EMC_STROBE: begin
        if (!s_reg.write) begin
          s_next.resp_data = ad_in;
        end else begin
          s_next.resp_data = 8'h00;
        end
        s_next.rd_n = 1'b1;
        s_next.wr_n = 1'b1;
        s_next.st   = emc_pkg::EMC_FINISH;
      end
      emc_pkg::EMC_FINISH: begin
        s_next.ad_oe      = 1'b0;
        s_next.lo_oe      = 1'b0;
        s_next.hi_oe      = 1'b0;
        s_next.resp_valid = 1'b1;
        s_next.st         = emc_pkg::EMC_IDLE;
      end
      default: begin
        s_next.st = emc_pkg::EMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg       <= '0;
      s_reg.st    <= emc_pkg::EMC_IDLE;
      s_reg.cfg   <= emc_pkg::CFG_RESET;
      s_reg.page  <= emc_pkg::PAGE_RESET;
      s_reg.rd_n  <= 1'b1;
      s_reg.wr_n  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
    if (ram_we) begin
      ram[ram_idx] <= q_wdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cfg_rdata   = s_reg.cfg;
  assign page_rdata  = s_reg.page;
  assign resp_valid  = s_reg.resp_valid;
  assign resp_data   = s_reg.resp_data;
  assign busy        = (s_reg.st != emc_pkg::EMC_IDLE);
  assign ad_out      = s_reg.ad_out;
  assign ad_oe       = s_reg.ad_oe;
  assign addr_lo_out = s_reg.lo_out;
  assign addr_lo_oe  = s_reg.lo_oe; // RQ7
  assign addr_hi_out = s_reg.hi_out;
  assign addr_hi_oe  = s_reg.hi_oe;
  assign ale_out     = s_reg.ale;
  assign rd_n_out    = s_reg.rd_n;
  assign wr_n_out    = s_reg.wr_n;
endmodule : emc_ext_mem

//--- hw/emc_pkg.sv
// Purpose: constants and types shared by the external memory interface
// Assumes: core clock ref_clk at 40 MHz, all timing counted in its cycles
// Notes:   configuration register layout and memory map modes
package emc_pkg;
  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET      = 8'h03;
  localparam logic [7:0] PAGE_RESET     = 8'h00;
  localparam int         CFG_SHARE_BIT  = 4;
  localparam int         CFG_MODE_LSB   = 2;
  localparam int         CFG_ALE_LSB    = 0;
  localparam logic [7:0] CFG_USED_MASK  = 8'h1F;

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam int          RAM_AW        = 10;
  localparam int          RAM_WORDS     = 1024;
  localparam logic [15:0] INT_RAM_LIMIT = 16'h0400;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          REQ_W         = 26;

  typedef enum logic [1:0] {
    EMC_MAP_INTERNAL = 2'h0,
    EMC_MAP_SPLIT    = 2'h1,
    EMC_MAP_BANKED   = 2'h2,
    EMC_MAP_EXTERNAL = 2'h3
  } emc_map_type;

  // gray codes along the usual path up to FINISH; FINISH back to IDLE flips two bits
  typedef enum logic [2:0] {
    EMC_IDLE   = 3'h0,
    EMC_ALE_HI = 3'h1,
    EMC_ALE_LO = 3'h3,
    EMC_STROBE = 3'h2,
    EMC_FINISH = 3'h6
  } emc_state_type;

  // latch pulse field to cycles minus one (00 -> 1 cycle ... 11 -> 4)
  function automatic logic [1:0] emc_ale_count(input logic [1:0] field);
    emc_ale_count = field;
  endfunction : emc_ale_count
endpackage : emc_pkg

//--- testbench/emc_ext_mem_asserts.sv
// Purpose: bus phase checks on the external memory interface
// Assumes: configuration is only written while the sequencer is idle
// Notes:   bound to emc_ext_mem in the testbench top
`timescale 1ns/1ps
module emc_ext_mem_asserts (
  // clock, reset, configuration
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  // bus pins
  input wire logic       ale_out,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe,
  input wire logic       rd_n_out,
  input wire logic       wr_n_out,
  input wire logic       resp_valid
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ----
  // assertions
  // ----
  cfg_mask_a: assert property (cfg_wr |=> cfg_rdata == ($past(cfg_wdata) & 8'h1F))
    else $error("configuration readback wrong");
  ale_drive_a: assert property (ale_out |-> ad_oe)
    else $error("latch strobe high without address driven");
  ale_hold_a: assert property (ale_out && $past(ale_out) |-> $stable(ad_out))
    else $error("low address moved during latch phase");
  ale_sep_a: assert property ($rose(ale_out) |-> !cfg_rdata[4])
    else $error("latch strobe in separate pin style");
  ale_short_a: assert property ($rose(ale_out) && cfg_rdata[1:0] == 2'h0 |=>
    !ale_out ##1 (!rd_n_out || !wr_n_out)) else $error("short latch phase wrong");
  ale_long_a: assert property ($rose(ale_out) && cfg_rdata[1:0] == 2'h3 |->
    ale_out[*4] ##1 !ale_out[*4] ##1 (!rd_n_out || !wr_n_out))
    else $error("long latch phase wrong");
  wr_data_a: assert property ($fell(wr_n_out) && !cfg_rdata[4] |-> ad_oe && !ale_out)
    else $error("write data not on shared pins");
  rd_float_a: assert property (!rd_n_out |-> !ad_oe)
    else $error("pins driven during read strobe");
  strobe_resp_a: assert property ($fell(rd_n_out) || $fell(wr_n_out) |=>
    rd_n_out && wr_n_out ##1 resp_valid) else $error("strobe to response timing wrong");
endmodule : emc_ext_mem_asserts

//--- testbench/emc_ext_mem_tb.sv
// Purpose: self-checking bench for the external memory interface
// Assumes: inputs change on the falling edge
// Notes:   each scenario is a task
`timescale 1ns/1ps
module emc_ext_mem_tb;
  logic        ref_clk = 1'h0, reset = 1'h1, cfg_wr = 1'h0, page_wr = 1'h0;
  logic        req_valid = 1'h0, req_write = 1'h0, req_short = 1'h0;
  logic [7:0]  cfg_wdata = 8'h00, page_wdata = 8'h00, req_wdata = 8'h00;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0]  cfg_rdata, page_rdata, resp_data, ad_in, ad_out, addr_lo_out, addr_hi_out;
  logic        req_ready, resp_valid, busy, ad_oe, addr_lo_oe, addr_hi_oe;
  logic        ale_out, rd_n_out, wr_n_out, hoe_v;
  logic [7:0]  rd_v, lo_v, hi_v, wd_v;
  int          err_total = 0, total_checks = 0, ale_n;
  emc_ext_mem dut_u (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .cfg_wr      (cfg_wr),
    .cfg_wdata   (cfg_wdata),
    .cfg_rdata   (cfg_rdata),
    .page_wr     (page_wr),
    .page_wdata  (page_wdata),
    .page_rdata  (page_rdata),
    .req_valid   (req_valid),
    .req_ready   (req_ready),
    .req_write   (req_write),
    .req_short   (req_short),
    .req_addr    (req_addr),
    .req_wdata   (req_wdata),
    .resp_valid  (resp_valid),
    .resp_data   (resp_data),
    .busy        (busy),
    .ad_in       (ad_in),
    .ad_out      (ad_out),
    .ad_oe       (ad_oe),
    .addr_lo_out (addr_lo_out),
    .addr_lo_oe  (addr_lo_oe),
    .addr_hi_out (addr_hi_out),
    .addr_hi_oe  (addr_hi_oe),
    .ale_out     (ale_out),
    .rd_n_out    (rd_n_out),
    .wr_n_out    (wr_n_out)
  );
  emc_sram_model mem_u (
    .ref_clk     (ref_clk),
    .ale_out     (ale_out),
    .ad_out      (ad_out),
    .addr_lo_out (addr_lo_out),
    .addr_lo_oe  (addr_lo_oe),
    .rd_n_out    (rd_n_out),
    .wr_n_out    (wr_n_out),
    .ad_in       (ad_in)
  );
  initial forever #12.5 ref_clk = ~ref_clk;
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic wcfg(input logic [7:0] c, input logic [7:0] p);
    cfg_wdata = c;
    page_wdata = p;
    cfg_wr = 1'h1;
    page_wr = 1'h1;
    @(negedge ref_clk);
    cfg_wr = 1'h0;
    page_wr = 1'h0;
  endtask : wcfg
  task automatic xfer(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
    int k;
    req_write = w;
    req_short = s;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'h1;
    @(negedge ref_clk);
    req_valid = 1'h0;
    ale_n = 0;
    hoe_v = 1'h0;
    {lo_v, hi_v, wd_v} = 24'h000000;
    k = 0;
    while (resp_valid !== 1'h1) begin
      if (ale_out === 1'h1) begin
        ale_n++;
        lo_v = ad_out;
      end
      if (addr_hi_oe === 1'h1) begin
        hoe_v = 1'h1;
        hi_v = addr_hi_out;
      end
      if (wr_n_out === 1'h0) wd_v = ad_out;
      if (addr_lo_oe === 1'h1) lo_v = addr_lo_out;
      k++;
      if (k > 40) begin
        err_total++;
        test_done();
      end
      @(negedge ref_clk);
    end
    rd_v = resp_data;
    // response cycle: sequencer idle, every pin released, strobes high
    chk("pins released", 16'({busy, ad_oe, addr_lo_oe, addr_hi_oe, ale_out, rd_n_out, wr_n_out}),
        16'h0003);
  endtask : xfer
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    chk("cfg reset", 16'(cfg_rdata), 16'h0003);
    chk("page reset", 16'(page_rdata), 16'h0000);
    wcfg(8'hFF, 8'h12);
    chk("cfg unused bits", 16'(cfg_rdata), 16'h001F);
    chk("page", 16'(page_rdata), 16'h0012);
  endtask : t_regs
  task automatic t_internal();
    wcfg(8'h00, 8'h00);
    xfer(1'h1, 1'h0, 16'h0005, 8'h3C);
    xfer(1'h0, 1'h0, 16'h0405, 8'h00);
    chk("wrapped read", 16'(rd_v), 16'h003C);
    chk("no latch", 16'(ale_n), 16'h0000);
  endtask : t_internal
  task automatic t_shared();
    for (int f = 0; f < 4; f++) begin
      wcfg(8'(8'h04 + f), 8'h00);
      xfer(1'h1, 1'h0, 16'(16'h1230 + f), 8'(8'hA0 + f));
      chk("latch cycles", 16'(ale_n), 16'(f + 1));
      chk("latched low", 16'(lo_v), 16'(16'h0030 + f));
      chk("high pins", 16'(hi_v), 16'h0012);
      chk("shared data", 16'(wd_v), 16'(16'h00A0 + f));
      xfer(1'h0, 1'h0, 16'(16'h1230 + f), 8'h00);
      chk("shared read", 16'(rd_v), 16'(16'h00A0 + f));
    end
  endtask : t_shared
  task automatic t_separate();
    wcfg(8'h14, 8'h00);
    xfer(1'h1, 1'h0, 16'h0855, 8'h66);
    chk("sep low addr", 16'(lo_v), 16'h0055);
    chk("sep data", 16'(wd_v), 16'h0066);
    chk("sep no latch", 16'(ale_n), 16'h0000);
    xfer(1'h0, 1'h0, 16'h0855, 8'h00);
    chk("sep read", 16'(rd_v), 16'h0066);
  endtask : t_separate
  task automatic t_short();
    for (int m = 1; m < 4; m++) begin
      wcfg(8'(m * 4), 8'h12);
      xfer(1'h1, 1'h1, 16'(16'hFF40 + m), 8'(8'h70 + m));
      chk("short hi driven", 16'(hoe_v), 16'(m == 2));
      chk("short hi", 16'(hi_v), (m == 2) ? 16'h0012 : 16'h0000);
      chk("short low", 16'(lo_v), 16'(16'h0040 + m));
    end
    xfer(1'h1, 1'h0, 16'h0007, 8'h11);
    chk("ext only low", 16'(lo_v), 16'h0007);
    chk("ext only hi", 16'(hoe_v), 16'h0001);
  endtask : t_short
  task automatic t_fifo();
    int acc, rsp;
    logic full;
    acc = 0;
    rsp = 0;
    full = 1'h0;
    wcfg(8'h0F, 8'h00);
    req_write = 1'h1;
    req_short = 1'h0;
    req_valid = 1'h1;
    for (int i = 0; i < 20; i++) begin
      req_addr = 16'(16'h0100 + i);
      if (req_ready === 1'h1) acc++;
      else full = 1'h1;
      @(negedge ref_clk);
      if (resp_valid === 1'h1) rsp++;
    end
    req_valid = 1'h0;
    for (int i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if (resp_valid === 1'h1) rsp++;
    end
    chk("fifo refused", 16'(full), 16'h0001);
    chk("responses", 16'(rsp), 16'(acc));
  endtask : t_fifo
  initial begin
    repeat (2) @(negedge ref_clk);
    reset = 1'h0;
    t_regs();
    t_internal();
    t_shared();
    t_separate();
    t_short();
    t_fifo();
    test_done();
  end
endmodule : emc_ext_mem_tb
bind emc_ext_mem emc_ext_mem_asserts chk_u (
  .ref_clk    (ref_clk),
  .reset      (reset),
  .cfg_wr     (cfg_wr),
  .cfg_wdata  (cfg_wdata),
  .cfg_rdata  (cfg_rdata),
  .ale_out    (ale_out),
  .ad_out     (ad_out),
  .ad_oe      (ad_oe),
  .rd_n_out   (rd_n_out),
  .wr_n_out   (wr_n_out),
  .resp_valid (resp_valid)
);

//--- testbench/emc_sram_model.sv
// Purpose: external byte memory with transparent address latch
// Assumes: one strobe cycle per transfer
// Notes:   256 bytes keyed by the low address byte
`timescale 1ns/1ps
module emc_sram_model (
  // bus pins
  input  wire logic       ref_clk,
  input  wire logic       ale_out,
  input  wire logic [7:0] ad_out,
  input  wire logic [7:0] addr_lo_out,
  input  wire logic       addr_lo_oe,
  input  wire logic       rd_n_out,
  input  wire logic       wr_n_out,
  output logic      [7:0] ad_in
);
  logic [7:0] mem [0:255];
  logic [7:0] q;
  logic [7:0] a;
  logic [7:0] last = 8'hA5;
  // follows while strobe high, frozen once it falls
  always_latch if (ale_out) q <= ad_out;
  assign a = addr_lo_oe ? addr_lo_out : q;
  // released bus shows the inverse of the last byte read
  assign ad_in = !rd_n_out ? mem[a] : ~last;
  always @(posedge ref_clk) begin
    if (!wr_n_out) mem[a] <= ad_out;
    if (!rd_n_out) last <= mem[a];
  end
endmodule : emc_sram_model
